// *** hw/ldsc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldsc_top #(
  parameter int TEST_CYC = ldsc_pkg::LDSC_TEST_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // laser analog front end
  input  wire logic        cathode_leak,
  input  wire logic        cathode_low,
  output logic             laser_current_node,
  output logic             continuous_drive,
  output logic             cathode_probe,
  output logic             supply_switch_n,
  // interrupt
  output logic             irq
);
  // register state
  logic [7:0]                   ctrl_reg;
  logic [ldsc_pkg::LDSC_ST_W-1:0] status_reg;
  logic [ldsc_pkg::LDSC_ST_W-1:0] mask_reg;
  logic                         fault_reg;
  logic [31:0]                  prdata_reg;
  logic                         pready_reg;
  logic                         pslverr_reg;
  logic                         drive_reg;
  logic                         cw_reg;
  logic                         probe_reg;
  logic                         switch_n_reg;
  logic                         irq_reg;

  // apb decode
  wire setup   = psel && !penable;
  wire access  = psel && penable && pready_reg;
  wire wr      = access && pwrite;
  wire hit_ctl = (paddr == ldsc_pkg::LDSC_CTRL_ADDR);
  wire hit_st  = (paddr == ldsc_pkg::LDSC_STATUS_ADDR);
  wire hit_msk = (paddr == ldsc_pkg::LDSC_MASK_ADDR);
  wire hit_tst = (paddr == ldsc_pkg::LDSC_TEST_ADDR);
  wire mapped  = hit_ctl || hit_st || hit_msk || hit_tst;
  wire wr_ctl  = wr && hit_ctl && pstrb[0];
  wire wr_st   = wr && hit_st && pstrb[0];
  wire wr_msk  = wr && hit_msk && pstrb[0];
  wire kick    = wr && hit_tst && pstrb[0] && pwdata[0];

  // control decode
  wire [2:0] mode      = ctrl_reg[ldsc_pkg::LDSC_MODE_LSB +: ldsc_pkg::LDSC_MODE_W];
  wire       force_off = ctrl_reg[ldsc_pkg::LDSC_FORCE_OFF_BIT];
  wire       cal_mode  = (mode == ldsc_pkg::LDSC_MODE_CAL);

  // self-test engine
  logic st_dark;
  logic st_probe;
  logic st_fail;
  logic st_done;
  ldsc_self_test #(.TEST_CYC(TEST_CYC)) u_test (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (!fault_reg),
    .kick        (kick),
    .cathode_low (cathode_low),
    .dark        (st_dark),
    .probe_gnd   (st_probe),
    .fail        (st_fail),
    .done        (st_done)
  );

  // pulse train
  logic pulse;
  ldsc_pulse_gen u_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (!force_off && !cal_mode),
    .pulse   (pulse)
  );

  // leakage only counts while the probe is not grounding the node itself
  wire leak_evt  = cathode_leak && !st_probe;
  wire fault_set = leak_evt || st_fail;
  wire fault_now = fault_reg || fault_set;

  wire drive_ok   = !force_off && !fault_now && !st_dark;
  wire drive_next = drive_ok && (cal_mode || pulse);
  wire [ldsc_pkg::LDSC_ST_W-1:0] evt = {st_done, st_fail, leak_evt};
  wire [ldsc_pkg::LDSC_ST_W-1:0] status_next =
    (status_reg & ~(wr_st ? pwdata[ldsc_pkg::LDSC_ST_W-1:0] : '0)) | evt;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    rd_mux = 32'h0000_0000;
    if (a == ldsc_pkg::LDSC_CTRL_ADDR) rd_mux = {24'h000000, ctrl_reg};
    if (a == ldsc_pkg::LDSC_STATUS_ADDR) rd_mux = {29'h0, status_reg};
    if (a == ldsc_pkg::LDSC_MASK_ADDR) rd_mux = {29'h0, mask_reg};
    if (a == ldsc_pkg::LDSC_TEST_ADDR) rd_mux = {31'h0, st_dark};
  endfunction : rd_mux

  // apb: no wait states, read data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg  <= (setup && !pwrite) ? rd_mux(paddr) : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= ldsc_pkg::LDSC_CTRL_RESET;
      mask_reg   <= '0;
      status_reg <= '0;
    end else begin
      if (wr_ctl) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (wr_msk) begin
        mask_reg <= pwdata[ldsc_pkg::LDSC_ST_W-1:0];
      end
      status_reg <= status_next;
    end
  end

  // fault stays latched until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg <= 1'b0;
    end else if (fault_set) begin
      fault_reg <= 1'b1;
    end
  end

  // laser outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_reg    <= 1'b0;
      cw_reg       <= 1'b0;
      probe_reg    <= 1'b0;
      switch_n_reg <= 1'b1;
      irq_reg      <= 1'b0;
    end else begin
      drive_reg    <= drive_next;
      cw_reg       <= drive_ok && cal_mode;
      probe_reg    <= st_probe;
      switch_n_reg <= fault_now || st_dark;
      irq_reg      <= |(status_next & mask_reg);
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign laser_current_node = drive_reg;
  assign continuous_drive   = cw_reg;
  assign cathode_probe      = probe_reg;
  assign supply_switch_n    = switch_n_reg;
  assign irq                = irq_reg;
endmodule : ldsc_top
`default_nettype wire

// *** hw/ldsc_pkg.sv ***
`default_nettype none
package ldsc_pkg;
  // register byte addresses
  localparam logic [7:0] LDSC_CTRL_ADDR   = 8'h20;
  localparam logic [7:0] LDSC_STATUS_ADDR = 8'h24;
  localparam logic [7:0] LDSC_MASK_ADDR   = 8'h28;
  localparam logic [7:0] LDSC_TEST_ADDR   = 8'h2C;
  // control fields
  localparam int         LDSC_FORCE_OFF_BIT = 0;
  localparam int         LDSC_MODE_LSB      = 1;
  localparam int         LDSC_MODE_W        = 3;
  localparam logic [2:0] LDSC_MODE_CAL      = 3'h2;
  localparam logic [7:0] LDSC_CTRL_RESET    = 8'h01;
  // status bits
  localparam int         LDSC_ST_W          = 3;
  localparam int         LDSC_ST_LEAK       = 0;
  localparam int         LDSC_ST_SELFTEST   = 1;
  localparam int         LDSC_ST_TEST_DONE  = 2;
  // timing
  localparam int         LDSC_CLK_HZ        = 25000000;
  localparam int         LDSC_PULSE_NS      = 200;
  localparam int         LDSC_PERIOD_NS     = 1000;
  localparam int         LDSC_PULSE_CYC     = (LDSC_PULSE_NS * (LDSC_CLK_HZ / 1000000) + 999) / 1000;
  localparam int         LDSC_PERIOD_CYC    = (LDSC_PERIOD_NS * (LDSC_CLK_HZ / 1000000)) / 1000;
  localparam int         LDSC_TEST_US       = 1000;
  localparam int         LDSC_TEST_CYC      = LDSC_TEST_US * (LDSC_CLK_HZ / 1000000);
  localparam int         LDSC_SETTLE_CYC    = 4;
  localparam int         LDSC_CNT_W         = 24;

  typedef enum logic [1:0] {
    LDSC_ST_IDLE   = 2'b00,
    LDSC_ST_DARK   = 2'b01,
    LDSC_ST_PROBE  = 2'b10,
    LDSC_ST_FAULT  = 2'b11
  } ldsc_state_t;
endpackage : ldsc_pkg
`default_nettype wire

// *** hw/ldsc_pulse_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldsc_pulse_gen (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic run,
  // pulse train
  output logic      pulse
);
  logic [7:0] cnt_reg;
  wire        wrap = (cnt_reg == 8'(ldsc_pkg::LDSC_PERIOD_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else if (!run || wrap) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  assign pulse = run && (cnt_reg < 8'(ldsc_pkg::LDSC_PULSE_CYC));
endmodule : ldsc_pulse_gen
`default_nettype wire

// *** hw/ldsc_self_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldsc_self_test #(
  parameter int TEST_CYC = ldsc_pkg::LDSC_TEST_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic enable,
  input  wire logic kick,
  input  wire logic cathode_low,
  // results
  output logic      dark,
  output logic      probe_gnd,
  output logic      fail,
  output logic      done
);
  ldsc_pkg::ldsc_state_t state_reg, state_next;
  logic [ldsc_pkg::LDSC_CNT_W-1:0] cnt_reg, cnt_next;

  wire timer_hit  = (cnt_reg == ldsc_pkg::LDSC_CNT_W'(TEST_CYC - 1));
  wire settle_hit = (cnt_reg == ldsc_pkg::LDSC_CNT_W'(ldsc_pkg::LDSC_SETTLE_CYC - 1));

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 1'b1;
    fail       = 1'b0;
    done       = 1'b0;
    case (state_reg)
      ldsc_pkg::LDSC_ST_IDLE: begin
        if (!enable) begin
          cnt_next = '0;
        end else if (timer_hit || kick) begin
          state_next = ldsc_pkg::LDSC_ST_DARK;
          cnt_next   = '0;
        end
      end
      ldsc_pkg::LDSC_ST_DARK: begin
        if (settle_hit) begin
          state_next = ldsc_pkg::LDSC_ST_PROBE;
          cnt_next   = '0;
        end
      end
      ldsc_pkg::LDSC_ST_PROBE: begin
        if (settle_hit) begin
          // node held up by a rail: the probe could not pull it down
          fail       = !cathode_low;
          done       = 1'b1;
          state_next = ldsc_pkg::LDSC_ST_IDLE;
          cnt_next   = '0;
        end
      end
      default: begin
        state_next = ldsc_pkg::LDSC_ST_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ldsc_pkg::LDSC_ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign dark      = (state_reg != ldsc_pkg::LDSC_ST_IDLE);
  assign probe_gnd = (state_reg == ldsc_pkg::LDSC_ST_PROBE);
endmodule : ldsc_self_test
`default_nettype wire

// *** verification/ldsc_pfet_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldsc_pfet_model (
  // gate and cathode node
  input  wire logic supply_switch_n,
  input  wire logic cathode_probe,
  input  wire logic rail_short,
  output logic      supply_on,
  output logic      cathode_low
);
  assign supply_on   = !supply_switch_n;
  // a rail short holds the node high even while it is grounded
  assign cathode_low = cathode_probe && !rail_short;
endmodule : ldsc_pfet_model
`default_nettype wire

// *** verification/ldsc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldsc_checker #(
  parameter int TEST_CYC = ldsc_pkg::LDSC_TEST_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // laser side
  input wire logic cathode_leak,
  input wire logic cathode_low,
  input wire logic laser_current_node,
  input wire logic continuous_drive,
  input wire logic cathode_probe,
  input wire logic supply_switch_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access not answered in one cycle");
  err_qual_a: assert property (pslverr |-> pready) else $error("error without ready");
  leak_cut_a: assert property (
    cathode_leak && !supply_switch_n |=> supply_switch_n && !laser_current_node)
    else $error("leak did not cut drive");
  fault_hold_a: assert property (
    cathode_leak && !supply_switch_n |=> supply_switch_n [*8])
    else $error("fault did not hold");
  switch_gate_a: assert property (supply_switch_n |-> !laser_current_node)
    else $error("drive on with supply cut");
  probe_dark_a: assert property (
    $rose(cathode_probe) |-> supply_switch_n && $past(supply_switch_n, 4))
    else $error("probe without dark phase");
  pulse_short_a: assert property (
    laser_current_node && !continuous_drive |-> ##[1:5] !laser_current_node)
    else $error("pulse too long");
  cw_hold_a: assert property (
    continuous_drive && laser_current_node |=>
      laser_current_node || supply_switch_n || !continuous_drive)
    else $error("steady drive dropped");
  test_fail_a: assert property (
    $fell(cathode_probe) && !$past(cathode_low) |-> ##1 supply_switch_n [*6])
    else $error("failed self-test not shut down");
  cover property (continuous_drive && laser_current_node);
  cover property ($fell(cathode_probe) && !$past(cathode_low));
  cover property (cathode_leak && !supply_switch_n);
endmodule : ldsc_checker
bind ldsc_top ldsc_checker #(.TEST_CYC(TEST_CYC)) chk_i (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .cathode_leak, .cathode_low, .laser_current_node, .continuous_drive,
  .cathode_probe, .supply_switch_n);
`default_nettype wire

// *** verification/laser_drive_safety_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module laser_drive_safety_control_tb;
  logic        pclk, presetn, psel, penable, pwrite, cathode_leak, rail_short, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, laser_current_node, continuous_drive, cathode_probe;
  logic        supply_switch_n, irq, cathode_low, supply_on;
  int          errors, n_compared, cycles, k, hi;
  // short self-test interval keeps the run brief
  ldsc_top #(.TEST_CYC(300)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .cathode_leak, .cathode_low,
    .laser_current_node, .continuous_drive, .cathode_probe, .supply_switch_n, .irq);
  ldsc_pfet_model pm (.supply_switch_n, .cathode_probe, .rail_short, .supply_on,
    .cathode_low);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask : apb
  task automatic rst();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst
  // count active drive and switch-high cycles over a window
  task automatic watch(input int n);
    hi = 0;
    k  = 0;
    repeat (n) begin
      @(posedge pclk);
      hi += (laser_current_node !== 1'b0);
      k  += (supply_switch_n !== 1'b0);
    end
  endtask : watch
  task automatic probe_run();
    apb(1'b1, 8'h2C, 32'h1);
    for (int i = 0; i < 20 && cathode_probe !== 1'b1; i++) @(posedge pclk);
    chk(supply_switch_n, 1'b1);
    for (int i = 0; i < 20 && cathode_probe !== 1'b0; i++) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask : probe_run
  initial begin
    {psel, penable, pwrite, cathode_leak, rail_short, paddr, pwdata} = '0;
    pstrb   = 4'hF;
    presetn = 1'b0;
    void'($urandom(20));
    rst();
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, {24'h0, ldsc_pkg::LDSC_CTRL_RESET});
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, er}, 32'h1);
    // write without lane 0 must leave control untouched
    pstrb <= 4'hE;
    apb(1'b1, 8'h20, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, {24'h0, ldsc_pkg::LDSC_CTRL_RESET});
    watch(30);
    chk(hi, 32'h0);
    $display("test 1 done");
    apb(1'b1, 8'h28, 32'h3);
    apb(1'b1, 8'h20, 32'h0);
    watch(3);
    watch(ldsc_pkg::LDSC_PERIOD_CYC);
    if (k == 0) chk(hi, ldsc_pkg::LDSC_PULSE_CYC);
    chk(k, 32'h0);
    $display("test 2 done");
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, 8'h20, ($urandom & 32'hFFFFFF00) | (m << 1));
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, m << 1);
      repeat (3) @(posedge pclk);
      chk(continuous_drive, m[2:0] == ldsc_pkg::LDSC_MODE_CAL);
      if (m == 2 && supply_switch_n === 1'b0) chk(laser_current_node, 1'b1);
    end
    $display("test 3 done");
    probe_run();
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h4);
    chk(irq, 1'b0);
    apb(1'b1, 8'h28, 32'h7);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, 8'h24, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    $display("test 4 done");
    rail_short <= 1'b1;
    probe_run();
    apb(1'b0, 8'h24, 32'h0);
    chk(rd[1], 1'b1);
    chk(supply_on, 1'b0);
    $display("test 5 done");
    rail_short <= 1'b0;
    rst();
    apb(1'b1, 8'h20, 32'h0);
    repeat ($urandom % 20 + 5) @(posedge pclk);
    cathode_leak <= 1'b1;
    @(posedge pclk);
    cathode_leak <= 1'b0;
    apb(1'b1, 8'h20, 32'h0);
    watch(30);
    chk(hi, 32'h0);
    chk(k, 32'd30);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, 8'h28, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    $display("test 6 done");
    tally_and_finish();
  end
endmodule : laser_drive_safety_control_tb
`default_nettype wire
